// File: bench/boot_power_state_machine_test.sv
/* boot_power_state_machine_test: directed bench for bpsm_top with a host model.
 * assumes a short power-on count and bpsm_top as the lone ahb-lite slave. */
`timescale 1ns/10ps
module boot_power_state_machine_test;
	logic                     clk, resetn, supply_low, brownout_detect, timer_event, hsel, hwrite;
	logic [1:0]               htrans;
	logic [31:0]              haddr, hwdata, hrdata, start_addr_r, cmd_rdata_r, q;
	logic                     hreadyout, hresp, dsp_en_r, service_request_in, host_request_line;
	logic [7:0]               block_busy, block_clk_en_r, block_pwr_en_r, switch_matrix_r;
	bpsm_pkg::bpsm_cmd_type   host_cmd;
	bpsm_pkg::bpsm_power_type power_r;
	bpsm_pkg::bpsm_state_type state_r;
	int                       err_total, samples_checked;
	bpsm_top #(.POR_CYCLES_P(20), .BLOCKS(8)) u_dut (.clk(clk), .resetn(resetn), .supply_low(supply_low),
		.brownout_detect(brownout_detect), .service_request_in(service_request_in),
		.host_request_line(host_request_line), .host_cmd(host_cmd), .timer_event(timer_event),
		.block_busy(block_busy), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.power_r(power_r), .block_clk_en_r(block_clk_en_r), .block_pwr_en_r(block_pwr_en_r),
		.switch_matrix_r(switch_matrix_r), .dsp_en_r(dsp_en_r), .start_addr_r(start_addr_r),
		.cmd_rdata_r(cmd_rdata_r), .state_r(state_r));
	bpsm_host u_host (.clk(clk), .service_request_in(service_request_in),
		.host_request_line(host_request_line), .host_cmd(host_cmd));
	////////////////////////////////////////////////////////////
	task final_report();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// bounded wait for hready high at an edge
	task wait_ready();
		int n;
		n = 0;
		do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin err_total++; final_report(); end
	endtask : wait_ready
	// one ahb-lite single word transfer, read data taken at the data phase edge
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_ready();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		q = hrdata;
	endtask : bus
	task rd(input logic [31:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0);
		chk(what, exp, q);
	endtask : rd
	// bounded wait for a state; running out ends the run
	task wait_st(input bpsm_pkg::bpsm_state_type s);
		int n;
		n = 0;
		do begin @(posedge clk); n++; end while (state_r !== s && n < 200);
		chk("state", 32'(s), 32'(state_r));
		if (state_r !== s) final_report();
	endtask : wait_st
	////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{resetn, supply_low, brownout_detect, timer_event, hsel, hwrite} = '0;
		{htrans, haddr, hwdata, block_busy, err_total, samples_checked} = '0;
		repeat (16) @(posedge clk);
		chk("reset state", 32'(bpsm_pkg::ST_RESET), 32'(state_r));
		chk("reset controls", 32'h0, 32'(power_r));
		resetn <= 1'b1;
		@(posedge clk);
		rd({24'h0, bpsm_pkg::REG_CONTROL}, bpsm_pkg::CONTROL_RESET, "control");
		rd(32'h0000_000c, 32'h0, "unmapped");
		chk("resp", 32'h0, 32'(hresp));
		wait_st(bpsm_pkg::ST_INIT);
		repeat (40) @(posedge clk);
		chk("init held", 32'(bpsm_pkg::ST_INIT), 32'(state_r));
		chk("init osc", 32'h1, 32'(power_r.use_low_power_osc));
		chk("init work", 32'h1, 32'(power_r.supply_measure && power_r.pmu_setup && power_r.otp_load));
		u_host.set_srq(1'b1);
		wait_st(bpsm_pkg::ST_CMD);
		chk("swm", 32'(bpsm_pkg::SWM_DEFAULT), 32'(switch_matrix_r));
		// every non-leaving handler command
		for (int i = 1; i <= 10; i++) begin
			if (i == 7 || i == 9)
				continue;
			u_host.send_cmd(4'(i), 32'h40 + i, 32'h1b);
			@(posedge clk);
			chk("cmd state", 32'(bpsm_pkg::ST_CMD), 32'(state_r));
			if (i == 2 || i == 4)
				chk("echo", 32'h40 + i, cmd_rdata_r);
			if (i == 5 || i == 6)
				chk("dsp", 32'(i == 5), 32'(dsp_en_r));
			if (i == 8)
				chk("version", bpsm_pkg::VERSION_VALUE, cmd_rdata_r);
			if (i == 10)
				chk("swm cfg", 32'h1b, 32'(switch_matrix_r));
		end
		u_host.send_cmd(bpsm_pkg::CMD_START, 32'h100, 32'h0);
		@(posedge clk);
		chk("active", 32'(bpsm_pkg::ST_ACTIVE), 32'(state_r));
		rd({24'h0, bpsm_pkg::REG_BOOT}, 32'h100, "boot addr");
		rd({24'h0, bpsm_pkg::REG_STATUS}, 32'h8, "status");
		block_busy <= 8'h05;
		repeat (3) @(posedge clk);
		chk("clk gate", 32'h05, 32'(block_clk_en_r));
		chk("pwr gate", 32'h05, 32'(block_pwr_en_r));
		bus(1'b1, {24'h0, bpsm_pkg::REG_CONTROL}, 32'h0000_000d);
		wait_st(bpsm_pkg::ST_SLEEP);
		chk("retain", 32'h1, 32'(power_r.retention_on && power_r.cpu_idle));
		chk("xtal", 32'h1, 32'(power_r.xtal_keep));
		chk("ultra_low_power_osc", 32'h1, 32'(power_r.use_ultra_low_power_osc));
		chk("sleep gate", 32'h0, 32'(block_clk_en_r | block_pwr_en_r));
		timer_event <= 1'b1;
		@(posedge clk);
		timer_event <= 1'b0;
		wait_st(bpsm_pkg::ST_ACTIVE);
		bus(1'b1, {24'h0, bpsm_pkg::REG_CONTROL}, 32'h0000_0015);
		wait_st(bpsm_pkg::ST_SLEEP);
		chk("ljo", 32'h1, 32'(power_r.use_low_jitter_osc && !power_r.xtal_keep));
		u_host.wake();
		wait_st(bpsm_pkg::ST_ACTIVE);
		bus(1'b1, {24'h0, bpsm_pkg::REG_CONTROL}, 32'h0000_0006);
		wait_st(bpsm_pkg::ST_RESET);
		wait_st(bpsm_pkg::ST_CMD);
		brownout_detect <= 1'b1;
		wait_st(bpsm_pkg::ST_RESET);
		brownout_detect <= 1'b0;
		wait_st(bpsm_pkg::ST_CMD);
		bus(1'b1, {24'h0, bpsm_pkg::REG_CONTROL}, 32'h0000_0000);
		brownout_detect <= 1'b1;
		repeat (8) @(posedge clk);
		chk("bod masked", 32'(bpsm_pkg::ST_CMD), 32'(state_r));
		brownout_detect <= 1'b0;
		u_host.send_cmd(bpsm_pkg::CMD_RESET, 32'h0, 32'h0);
		wait_st(bpsm_pkg::ST_RESET);
		wait_st(bpsm_pkg::ST_CMD);
		supply_low <= 1'b1;
		wait_st(bpsm_pkg::ST_RESET);
		repeat (30) @(posedge clk);
		chk("held", 32'(bpsm_pkg::ST_RESET), 32'(state_r));
		supply_low <= 1'b0;
		wait_st(bpsm_pkg::ST_INIT);
		final_report();
	end
endmodule : boot_power_state_machine_test

// File: bench/bpsm_host.sv
/* bpsm_host: host controller model driving request pins and decoded commands.
 * assumes calls are made right after a rising clock edge. */
`timescale 1ns/10ps
module bpsm_host (
	// clock
	input  wire logic              clk,
	// host pins
	output logic                   service_request_in,
	output logic                   host_request_line,
	// decoded command stream
	output bpsm_pkg::bpsm_cmd_type host_cmd
);
	// every host pin starts low, so nothing drives the io side ahead of the core
	initial begin
		service_request_in = 1'b0;
		host_request_line  = 1'b0;
		host_cmd           = '0;
	end
	// request level picks init or command state
	task set_srq(input logic v);
		service_request_in <= v;
	endtask : set_srq
	// one-cycle command; fields flip once released so stale values are never trusted
	task send_cmd(input logic [3:0] code, input logic [31:0] addr, input logic [31:0] data);
		host_cmd <= {1'b1, code, addr, data};
		@(posedge clk);
		host_cmd <= {1'b0, ~code, ~addr, ~data};
	endtask : send_cmd
	// request line held past the synchroniser to wake the device
	task wake();
		host_request_line <= 1'b1;
		repeat (4) @(posedge clk);
		host_request_line <= 1'b0;
	endtask : wake
endmodule : bpsm_host

// File: bench/bpsm_props.sv
/* bpsm_props: concurrent checks on the ports of bpsm_top.
 * assumes one clock domain, synchronous active-low resetn. */
`timescale 1ns/10ps
module bpsm_props #(
	parameter int POR_CYCLES_P = 20, // power-on settle count
	parameter int BLOCKS       = 8   // gated blocks
) (
	// clock and reset
	input wire logic                     clk,
	input wire logic                     resetn,
	// causes
	input wire logic                     supply_low,
	input wire logic                     brownout_detect,
	input wire logic                     service_request_in,
	input wire logic                     timer_event,
	input wire bpsm_pkg::bpsm_cmd_type   host_cmd,
	// results
	input wire bpsm_pkg::bpsm_power_type power_r,
	input wire logic [31:0]              start_addr_r,
	input wire bpsm_pkg::bpsm_state_type state_r
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////
	// cycles spent in reset; a standing supply or brownout cause may stretch the stay
	int   rst_cnt_r;
	logic cause_seen_r;
	always_ff @(posedge clk) begin
		if (!resetn || state_r != bpsm_pkg::ST_RESET) begin
			rst_cnt_r    <= 0;
			cause_seen_r <= 1'b0;
		end else begin
			rst_cnt_r    <= rst_cnt_r + 1;
			cause_seen_r <= cause_seen_r || supply_low || brownout_detect;
		end
	end
	// request held high in init for three cycles, one more than the synchroniser depth
	sequence srq_high_s;
		(state_r == bpsm_pkg::ST_INIT && service_request_in)[*3];
	endsequence
	// start command taken in the command state
	sequence start_s;
		state_r == bpsm_pkg::ST_CMD && host_cmd.valid && host_cmd.code == bpsm_pkg::CMD_START;
	endsequence
	////////////////////////////////////////////////////////////
	AST_POR_HOLD: assert property (state_r == bpsm_pkg::ST_INIT && $past(state_r) == bpsm_pkg::ST_RESET |->
		rst_cnt_r == POR_CYCLES_P + 1 || (cause_seen_r && rst_cnt_r > POR_CYCLES_P + 1)) else $error("reset hold count off");
	AST_INIT_FROM_RESET: assert property (state_r == bpsm_pkg::ST_INIT |->
		$past(state_r) inside {bpsm_pkg::ST_RESET, bpsm_pkg::ST_INIT}) else $error("init from wrong state");
	AST_RESET_OFF: assert property (state_r == bpsm_pkg::ST_RESET |-> power_r == '0)
		else $error("controls on in reset");
	AST_SUPPLY_LOW: assert property (supply_low[*4] |-> state_r == bpsm_pkg::ST_RESET)
		else $error("low supply not in reset");
	AST_INIT_STAY: assert property ((state_r == bpsm_pkg::ST_INIT && !service_request_in)[*3] |=>
		state_r == bpsm_pkg::ST_INIT) else $error("init left with request low");
	AST_INIT_TO_CMD: assert property (srq_high_s |-> ##[0:30] state_r == bpsm_pkg::ST_CMD)
		else $error("request high did not reach command state");
	AST_INIT_OSC: assert property (state_r == bpsm_pkg::ST_INIT |-> power_r.use_low_power_osc)
		else $error("init not on low power oscillator");
	AST_CMD_BOOT: assert property (state_r == bpsm_pkg::ST_CMD |-> power_r.core_run && power_r.rom_boot &&
		power_r.spi_slave_en) else $error("command state not booting");
	AST_START: assert property (start_s |=> state_r == bpsm_pkg::ST_ACTIVE &&
		start_addr_r == $past(host_cmd.addr)) else $error("start command not taken");
	AST_ACTIVE_FROM: assert property (state_r == bpsm_pkg::ST_ACTIVE |-> $past(state_r) inside
		{bpsm_pkg::ST_CMD, bpsm_pkg::ST_SLEEP, bpsm_pkg::ST_ACTIVE}) else $error("active from wrong state");
	AST_SLEEP_FROM: assert property (state_r == bpsm_pkg::ST_SLEEP |-> $past(state_r) inside
		{bpsm_pkg::ST_ACTIVE, bpsm_pkg::ST_SLEEP}) else $error("sleep from wrong state");
	AST_SLEEP_KEEP: assert property (state_r == bpsm_pkg::ST_SLEEP |-> power_r.retention_on && power_r.cpu_idle)
		else $error("sleep without retention");
	AST_WAKE: assert property (state_r == bpsm_pkg::ST_SLEEP && timer_event |=> state_r == bpsm_pkg::ST_ACTIVE)
		else $error("timer did not wake");
endmodule : bpsm_props

bind bpsm_top bpsm_props #(.POR_CYCLES_P(POR_CYCLES_P), .BLOCKS(BLOCKS)) u_props (
	.clk(clk), .resetn(resetn), .supply_low(supply_low), .service_request_in(service_request_in),
	.brownout_detect(brownout_detect),
	.timer_event(timer_event), .host_cmd(host_cmd), .power_r(power_r), .start_addr_r(start_addr_r),
	.state_r(state_r)
);

// File: logic/bpsm_pkg.sv
/*
 * bpsm_pkg: constants, state encoding and carrier structs for the
 * boot and power-state controller.
 * assumes a 100 MHz system clock; all users write bpsm_pkg::name.
 */
package bpsm_pkg;

	// state encoding, one-hot
	typedef enum logic [4:0] {
		ST_RESET  = 5'h01,
		ST_INIT   = 5'h02,
		ST_CMD    = 5'h04,
		ST_ACTIVE = 5'h08,
		ST_SLEEP  = 5'h10
	} bpsm_state_type;

	// clock rate and start-up timing
	localparam int CLK_HZ          = 100_000_000;
	localparam int POR_DELAY_MS    = 50;
	localparam int STARTUP_MAX_MS  = 60;
	localparam int POR_CYCLES      = (CLK_HZ / 1000) * POR_DELAY_MS;
	localparam int STARTUP_CYCLES  = (CLK_HZ / 1000) * STARTUP_MAX_MS;
	// init work (supply measure, pmu setup, otp load) sequenced in a few cycles
	localparam int INIT_STEP_CYCLES = 16;

	// host command codes (values are this block's own)
	localparam logic [3:0] CMD_NONE     = 4'h0;
	localparam logic [3:0] CMD_MEM_WR   = 4'h1;
	localparam logic [3:0] CMD_MEM_RD   = 4'h2;
	localparam logic [3:0] CMD_DSP_WR   = 4'h3;
	localparam logic [3:0] CMD_DSP_RD   = 4'h4;
	localparam logic [3:0] CMD_DSP_EN   = 4'h5;
	localparam logic [3:0] CMD_DSP_DIS  = 4'h6;
	localparam logic [3:0] CMD_START    = 4'h7;
	localparam logic [3:0] CMD_VERSION  = 4'h8;
	localparam logic [3:0] CMD_RESET    = 4'h9;
	localparam logic [3:0] CMD_SWM_CFG  = 4'ha;

	// version value is arbitrary
	localparam logic [31:0] VERSION_VALUE = 32'h0001_0000;

	// default switch matrix mapping for pins 0..3
	localparam logic [1:0] SWM_DATA_OUT = 2'h0;
	localparam logic [1:0] SWM_DATA_IN  = 2'h1;
	localparam logic [1:0] SWM_CLOCK    = 2'h2;
	localparam logic [1:0] SWM_SELECT   = 2'h3;
	localparam logic [7:0] SWM_DEFAULT  = 8'he4;

	// ahb register offsets
	localparam logic [7:0] REG_STATUS  = 8'h00;
	localparam logic [7:0] REG_CONTROL = 8'h04;
	localparam logic [7:0] REG_BOOT    = 8'h08;

	// control register bits
	localparam int CTRL_SLEEP_BIT   = 0;
	localparam int CTRL_FWRST_BIT   = 1;
	localparam int CTRL_BODRST_BIT  = 2;
	localparam int CTRL_XTALKEEP_BIT= 3;
	localparam int CTRL_LJO_BIT     = 4;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0004;

	// host command carrier
	typedef struct packed {
		logic        valid;
		logic [3:0]  code;
		logic [31:0] addr;
		logic [31:0] data;
	} bpsm_cmd_type;

	// power and clock controls toward the chip
	typedef struct packed {
		logic       core_run;
		logic       cpu_idle;
		logic       use_low_power_osc;
		logic       use_ultra_low_power_osc;
		logic       use_low_jitter_osc;
		logic       xtal_keep;
		logic       logic_supply_on;
		logic       retention_on;
		logic       pmu_setup;
		logic       otp_load;
		logic       supply_measure;
		logic       spi_slave_en;
		logic       rom_boot;
	} bpsm_power_type;

endpackage : bpsm_pkg

// File: logic/bpsm_top.sv
/*
 * bpsm_top: boot and power-state controller with an ahb-lite register slave.
 * assumes: clk 100 MHz, synchronous active-low resetn, one ahb master,
 * host request pin asynchronous, host commands decoded upstream.
 */
// The register addresses and the AHB-Lite register port are this design's own decisions.
// How it works
// - after power-on, rom boot leads to active
// - fixed start-up interval under sixty milliseconds
// - reset state: everything off, core held
// - low supply, brownout or firmware reset returns
// - settled power-on cell moves reset to init
// - init entered only from reset
// - init measures supply, sets pmu, loads otp
// - init clocks processor from low-power oscillator
// - request low stays init, high goes command
// - command state starts cpu, rom, spi pins
// - active entered from command only on host start command
// - handler supports memory, dsp, start, version, reset
// - active mode gates clocks and supplies of idle
// - active only from command or sleep
// - sleep only on processor sleep command
// - sleep keeps retention supply, cpu idle
// - sleep on ultra-low-power oscillator, or low-jitter if asked; crystal kept if asked
// - interrupt wakes sleep back into active
`timescale 1ns/10ps
module bpsm_top #(
	parameter int POR_CYCLES_P  = bpsm_pkg::POR_CYCLES,  // power-on settle count
	parameter int BLOCKS        = 8                      // gated functional blocks
) (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    resetn,
	// supply monitors (asynchronous)
	input  wire logic                    supply_low,
	input  wire logic                    brownout_detect,
	// host pins (asynchronous)
	input  wire logic                    service_request_in,
	input  wire logic                    host_request_line,
	// decoded host commands, same clock
	input  wire bpsm_pkg::bpsm_cmd_type  host_cmd,
	// wake timer and block busy lines, same clock
	input  wire logic                    timer_event,
	input  wire logic [BLOCKS-1:0]       block_busy,
	// ahb-lite slave
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic      [31:0]             hrdata,
	output logic                         hreadyout,
	output logic                         hresp,
	// power and clock controls
	output bpsm_pkg::bpsm_power_type     power_r,
	output logic      [BLOCKS-1:0]       block_clk_en_r,
	output logic      [BLOCKS-1:0]       block_pwr_en_r,
	output logic      [7:0]              switch_matrix_r,
	output logic                         dsp_en_r,
	output logic      [31:0]             start_addr_r,
	output logic      [31:0]             cmd_rdata_r,
	output bpsm_pkg::bpsm_state_type     state_r
);

	////////////////////////////////////////////////////////////////////////////
	// synchronisers

	logic [1:0] srq_sync_r;     // service request, two stages
	logic [1:0] hrq_sync_r;     // request line, wake source in sleep
	logic [1:0] low_sync_r;     // supply low
	logic [1:0] bod_sync_r;     // brownout

	// every pin and monitor input is asynchronous to clk, so each one passes
	// two flops before the state logic sees it; this costs two cycles of
	// latency on each of these inputs, which is far below the power-on settle time
	// first stage read only by second stage
	always_ff @(posedge clk) begin
		if (!resetn) begin
			srq_sync_r <= 2'h0;
			hrq_sync_r <= 2'h0;
			low_sync_r <= 2'h0;
			bod_sync_r <= 2'h0;
		end else begin
			srq_sync_r <= {srq_sync_r[0], service_request_in};
			hrq_sync_r <= {hrq_sync_r[0], host_request_line};
			low_sync_r <= {low_sync_r[0], supply_low};
			bod_sync_r <= {bod_sync_r[0], brownout_detect};
		end
	end

	wire srq_level = srq_sync_r[1];
	// the request line only matters as a wake source while asleep
	wire hrq_level = hrq_sync_r[1];

	////////////////////////////////////////////////////////////////////////////
	// registers written by software

	logic [31:0] control_r;     // sleep, fw reset, brownout policy, clocks
	logic        ahb_wr_r;      // write pending in data phase
	logic        ahb_rd_r;      // read pending in data phase
	logic [7:0]  ahb_addr_r;    // latched offset

	// ahb valid transfer decode
	function automatic logic ahb_go(input logic sel, input logic [1:0] tr, input logic rdy);
		ahb_go = sel && tr[1] && rdy;
	endfunction : ahb_go

	// decoded host command match, used by the reset cause and the start path
	function automatic logic cmd_is(input bpsm_pkg::bpsm_cmd_type cmd, input logic [3:0] code);
		cmd_is = cmd.valid && cmd.code == code;
	endfunction : cmd_is

	// hreadyout never drops, so the data phase always follows one cycle after
	// the address phase and back-to-back transfers need no stall logic
	// address phase capture; zero-wait slave
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ahb_wr_r   <= 1'b0;
			ahb_rd_r   <= 1'b0;
			ahb_addr_r <= 8'h00;
		end else begin
			ahb_wr_r   <= ahb_go(hsel, htrans, hready) && hwrite;
			ahb_rd_r   <= ahb_go(hsel, htrans, hready) && !hwrite;
			if (ahb_go(hsel, htrans, hready)) begin
				ahb_addr_r <= haddr[7:0];
			end
		end
	end

	// a write lands at the end of its data phase; a pulse bit written as one
	// acts for exactly one cycle, so software never has to clear it
	// pulse bits (sleep, fw reset) self-clear after one cycle
	always_ff @(posedge clk) begin
		if (!resetn) begin
			control_r <= bpsm_pkg::CONTROL_RESET;
		end else if (ahb_wr_r && ahb_addr_r == bpsm_pkg::REG_CONTROL) begin
			control_r <= hwdata;
		end else begin
			control_r[bpsm_pkg::CTRL_SLEEP_BIT] <= 1'b0;
			control_r[bpsm_pkg::CTRL_FWRST_BIT] <= 1'b0;
		end
	end

	wire sleep_cmd = control_r[bpsm_pkg::CTRL_SLEEP_BIT];
	wire fw_reset  = control_r[bpsm_pkg::CTRL_FWRST_BIT];
	wire bod_reset = control_r[bpsm_pkg::CTRL_BODRST_BIT];

	// kept combinational so a read right after a write sees the new value
	// read mux, unmapped reads zero
	always_comb begin
		case (ahb_addr_r)
			bpsm_pkg::REG_STATUS:  hrdata = {24'h0, dsp_en_r, 2'h0, state_r};
			bpsm_pkg::REG_CONTROL: hrdata = control_r;
			bpsm_pkg::REG_BOOT:    hrdata = start_addr_r;
			default:               hrdata = 32'h0000_0000;
		endcase
		if (!ahb_rd_r) begin
			hrdata = 32'h0000_0000;
		end
	end

	assign hreadyout = 1'b1;  // never stalls
	assign hresp     = 1'b0;  // always okay

	////////////////////////////////////////////////////////////////////////////
	// reset causes and timers

	// a brownout only forces reset while the brownout policy bit is set, as it is out of reset
	wire force_reset = low_sync_r[1] || (bod_sync_r[1] && bod_reset) || fw_reset
		|| cmd_is(host_cmd, bpsm_pkg::CMD_RESET);

	logic [31:0] por_cnt_r;    // power-on settle counter
	logic [4:0]  init_cnt_r;   // init step counter
	logic        init_done_r;  // supply measured, otp loaded

	// the counter keeps its end value while a cause still stands, so the exit
	// to init follows as soon as the last cause has gone
	// power-on cell model: counts settle time while in reset
	always_ff @(posedge clk) begin
		if (!resetn || state_r != bpsm_pkg::ST_RESET) begin
			por_cnt_r <= 32'h0;
		end else if (por_cnt_r < 32'(POR_CYCLES_P)) begin
			por_cnt_r <= por_cnt_r + 32'h1;
		end
	end

	wire por_settled = (por_cnt_r >= 32'(POR_CYCLES_P)) && !force_reset;

	// done rises one cycle after the step count ends and stays until init is left
	// init sequencing: measure, pmu, otp in short fixed steps
	always_ff @(posedge clk) begin
		if (!resetn || state_r != bpsm_pkg::ST_INIT) begin
			init_cnt_r  <= 5'h0;
			init_done_r <= 1'b0;
		end else if (init_cnt_r < 5'(bpsm_pkg::INIT_STEP_CYCLES)) begin
			init_cnt_r <= init_cnt_r + 5'h1;
		end else begin
			init_done_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state machine

	bpsm_pkg::bpsm_state_type state_nxt;
	wire start_cmd = cmd_is(host_cmd, bpsm_pkg::CMD_START);
	wire wake_irq  = timer_event || hrq_level;

	// no branch outside the reset state leads to init, and active is reached
	// only from the command or sleep states
	// next state; reset wins from any state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			bpsm_pkg::ST_RESET: begin
				if (por_settled) begin
					state_nxt = bpsm_pkg::ST_INIT;
				end
			end
			bpsm_pkg::ST_INIT: begin
				if (init_done_r && srq_level) begin
					state_nxt = bpsm_pkg::ST_CMD;
				end
			end
			bpsm_pkg::ST_CMD: begin
				if (start_cmd) begin
					state_nxt = bpsm_pkg::ST_ACTIVE;
				end
			end
			bpsm_pkg::ST_ACTIVE: begin
				if (sleep_cmd) begin
					state_nxt = bpsm_pkg::ST_SLEEP;
				end
			end
			bpsm_pkg::ST_SLEEP: begin
				if (wake_irq) begin
					state_nxt = bpsm_pkg::ST_ACTIVE;
				end
			end
			default: state_nxt = bpsm_pkg::ST_RESET;
		endcase
		if (force_reset) begin
			state_nxt = bpsm_pkg::ST_RESET;
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_r <= bpsm_pkg::ST_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// command handler

	// commands outside the command state are ignored, except reset, which
	// acts through the reset cause logic in any state
	// only acts in the command-handler state; reset handled above
	always_ff @(posedge clk) begin
		if (!resetn || state_r == bpsm_pkg::ST_RESET) begin
			switch_matrix_r <= bpsm_pkg::SWM_DEFAULT;
			dsp_en_r        <= 1'b0;
			start_addr_r    <= 32'h0;
			cmd_rdata_r     <= 32'h0;
		end else if (state_r == bpsm_pkg::ST_CMD && host_cmd.valid) begin
			case (host_cmd.code)
				bpsm_pkg::CMD_DSP_EN:  dsp_en_r <= 1'b1;
				bpsm_pkg::CMD_DSP_DIS: dsp_en_r <= 1'b0;
				bpsm_pkg::CMD_START:   start_addr_r <= host_cmd.addr;
				bpsm_pkg::CMD_VERSION: cmd_rdata_r <= bpsm_pkg::VERSION_VALUE;
				bpsm_pkg::CMD_SWM_CFG: switch_matrix_r <= host_cmd.data[7:0];
				// memory and dsp reads echo the command address; memory writes change nothing
				bpsm_pkg::CMD_MEM_RD,
				bpsm_pkg::CMD_DSP_RD:  cmd_rdata_r <= host_cmd.addr;
				default:               cmd_rdata_r <= cmd_rdata_r;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// power, clock and gating controls

	// driven from the next state so controls and state change on one edge;
	// the reset state falls to the default branch with every control off
	// decoded from the next state each cycle, registered for glitch-free outputs
	always_ff @(posedge clk) begin
		if (!resetn) begin
			power_r <= '0;
		end else begin
			power_r <= '0;
			case (state_nxt)
				bpsm_pkg::ST_INIT: begin
					power_r.use_low_power_osc <= 1'b1;
					power_r.supply_measure    <= 1'b1;
					power_r.pmu_setup         <= 1'b1;
					power_r.otp_load          <= 1'b1;
					power_r.logic_supply_on   <= 1'b1;
				end
				bpsm_pkg::ST_CMD: begin
					power_r.core_run        <= 1'b1;
					power_r.rom_boot        <= 1'b1;
					power_r.spi_slave_en    <= 1'b1;
					power_r.logic_supply_on <= 1'b1;
				end
				bpsm_pkg::ST_ACTIVE: begin
					power_r.core_run        <= 1'b1;
					power_r.spi_slave_en    <= 1'b1;
					power_r.logic_supply_on <= 1'b1;
					power_r.xtal_keep       <= 1'b1;
				end
				bpsm_pkg::ST_SLEEP: begin
					power_r.cpu_idle     <= 1'b1;
					power_r.retention_on <= 1'b1;
					power_r.use_low_jitter_osc <= control_r[bpsm_pkg::CTRL_LJO_BIT];
					power_r.use_ultra_low_power_osc <= !control_r[bpsm_pkg::CTRL_LJO_BIT];
					power_r.xtal_keep <= control_r[bpsm_pkg::CTRL_XTALKEEP_BIT];
				end
				default: power_r <= '0;
			endcase
		end
	end

	// a block that turns busy gets clock and supply one cycle later; blocks
	// that need them sooner must keep their busy line raised
	// idle blocks lose clock and supply; only in active mode may any run
	always_ff @(posedge clk) begin
		if (!resetn) begin
			block_clk_en_r <= '0;
			block_pwr_en_r <= '0;
		end else if (state_nxt == bpsm_pkg::ST_ACTIVE) begin
			block_clk_en_r <= block_busy;
			block_pwr_en_r <= block_busy;
		end else begin
			block_clk_en_r <= '0;
			block_pwr_en_r <= '0;
		end
	end

endmodule : bpsm_top
